// ---- verilog/core_defs.svh ----
// Overview of operation
// - One instruction cycle is four system clocks; execution advances in whole cycles.
// - Ordinary non-branching instructions complete in one instruction cycle.
// - Jump, call, return, interrupt return and table read take two cycles.
// - Writing program counter low jumps there and costs one extra cycle.
// - Conditional skip takes one cycle, plus one more when skipping.
// - Tests on a byte or bit proceed or skip the next instruction.
// - Call saves the following address; return resumes there.
// - Add sets carry above 255; subtract flags borrow below zero.
// - Increment and decrement change by one, into memory or accumulator.
// - AND, OR, XOR, complement set zero flag on zero result, into memory or accumulator.
// - Rotates shift one bit left or right, within byte or through carry.
// - Bit set and clear alter only the addressed bit of a byte.
// - Moves: memory to accumulator, accumulator to memory, immediate to accumulator.
// - Table read fetches fixed data from program memory into the accumulator.
// - Halt puts the core into its power-down condition.
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
`define PH_FIRST 2'h0
`define PH_LAST 2'h3
`define PH_STEP 2'h1
`define PCL_ADDR 8'h00
`define PC_STEP 8'h01
`define SKIP_STEP 8'h02
`define BYTE_ONE 8'h01
`define BYTE_ZERO 8'h00
`define BYTE_MAX 10'h0FF
`define SUB_DEST_MEM 0
`define SUB_CARRY 1
`define SUB_SUBTRACT 2
`define SUB_IMM 3
`define SUB_LOGIC_DEST 2
`define SUB_BIT_POL 3
`define SUB_INTERRUPT_RETURN_INSTR 0
`define STACK_STEP 1
`endif

// ---- verilog/core_pkg.sv ----
package core_pkg;
    typedef enum logic [3:0] {
        OP_LOAD_ACC = 4'b0000,
        OP_STORE_ACC = 4'b0001,
        OP_LOAD_IMM = 4'b0010,
        OP_ADDSUB = 4'b0011,
        OP_INCDEC = 4'b0100,
        OP_LOGIC = 4'b0101,
        OP_ROTATE = 4'b0110,
        OP_SKIP_BYTE = 4'b0111,
        OP_SKIP_BIT = 4'b1000,
        OP_BIT_SET = 4'b1001,
        OP_BIT_CLEAR = 4'b1010,
        OP_JUMP = 4'b1011,
        OP_CALL = 4'b1100,
        OP_RETURN = 4'b1101,
        OP_TABLE_READ = 4'b1110,
        OP_HALT = 4'b1111
    } opcode_e;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_EXTRA = 2'b01,
        ST_HALT = 2'b10
    } state_e;

    typedef struct packed {
        logic carry;
        logic zero;
    } flags_s;

    typedef struct packed {
        opcode_e op;
        logic [3:0] sub;
        logic [7:0] arg;
    } instr_s;
endpackage : core_pkg

// ---- verilog/mcu_instruction_execution.sv ----
`timescale 1ns/100ps
`include "core_defs.svh"
module mcu_instruction_execution #(
    parameter int DM_DEPTH = 16,
    parameter int STK_DEPTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Program memory, combinational read of pm_addr
    output logic [7:0] pm_addr,
    input wire core_pkg::instr_s pm_data,
    // Wake pin from outside
    input wire logic wake_pin,
    // Status
    output logic halted,
    output logic retire,
    output logic [7:0] acc,
    output core_pkg::flags_s flags
);
    localparam int DM_AW = $clog2(DM_DEPTH);
    localparam int SP_W = $clog2(STK_DEPTH);

    core_pkg::state_e st_q;
    logic [1:0] phase_q;
    logic [7:0] pc_q;
    logic [7:0] acc_q;
    core_pkg::flags_s flags_q;
    logic tbl_q;
    logic [7:0] mem_q [DM_DEPTH];
    logic [7:0] stk_q [STK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic wake1_q, wake2_q, wake3_q;

    core_pkg::instr_s ins;
    logic exec, extra_end, ordinary;
    logic [DM_AW-1:0] idx;
    logic [2:0] bsel;
    logic [7:0] mem_rd, opb, bit_mask, res_val;
    logic wr_acc, wr_mem, pcl_wr, is_skip, skip_taken, branch;
    logic new_carry, upd_carry, upd_zero;
    logic [8:0] sum9;
    logic [SP_W-1:0] sp_dn;

    function automatic logic [8:0] addsub9(input logic [7:0] a,
        input logic [7:0] b, input logic cin, input logic sub);
        // Bit 8 is carry out on add, borrow out on subtract
        if (sub) begin
            addsub9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        end else begin
            addsub9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        end
    endfunction : addsub9

    assign ins = pm_data;
    assign idx = ins.arg[DM_AW-1:0];
    assign bsel = ins.sub[2:0];
    assign bit_mask = `BYTE_ONE << bsel;
    assign exec = (st_q == core_pkg::ST_RUN) && (phase_q == `PH_LAST);
    assign extra_end = (st_q == core_pkg::ST_EXTRA) && (phase_q == `PH_LAST);
    // Program counter low reads back as live PC
    assign mem_rd = (ins.arg == `PCL_ADDR) ? pc_q : mem_q[idx];
    assign opb = ins.sub[`SUB_IMM] ? ins.arg : mem_rd;
    assign sum9 = addsub9(acc_q, opb, ins.sub[`SUB_CARRY] & flags_q.carry,
        ins.sub[`SUB_SUBTRACT]);
    assign sp_dn = sp_q - SP_W'(`STACK_STEP);
    assign pcl_wr = wr_mem && (ins.arg == `PCL_ADDR);
    assign is_skip = (ins.op == core_pkg::OP_SKIP_BYTE)
        || (ins.op == core_pkg::OP_SKIP_BIT);
    // Byte test: sub bit 0 low skips on zero, high on nonzero
    assign skip_taken = exec && (
        ((ins.op == core_pkg::OP_SKIP_BYTE)
            && ((mem_rd == `BYTE_ZERO) ^ ins.sub[0]))
        || ((ins.op == core_pkg::OP_SKIP_BIT)
            && (mem_rd[bsel] == ins.sub[`SUB_BIT_POL])));
    assign branch = (ins.op == core_pkg::OP_JUMP)
        || (ins.op == core_pkg::OP_CALL)
        || (ins.op == core_pkg::OP_RETURN)
        || (ins.op == core_pkg::OP_TABLE_READ)
        || pcl_wr || skip_taken;
    assign ordinary = !branch && (ins.op != core_pkg::OP_HALT);
    assign retire = (exec && ordinary) || extra_end;
    // Table address comes from the accumulator during the second cycle
    assign pm_addr = (st_q == core_pkg::ST_EXTRA && tbl_q) ? acc_q : pc_q;
    assign halted = (st_q == core_pkg::ST_HALT);
    assign acc = acc_q;
    assign flags = flags_q;

    always_comb begin
        res_val = acc_q;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        new_carry = flags_q.carry;
        upd_carry = 1'b0;
        upd_zero = 1'b0;
        case (ins.op)
            core_pkg::OP_LOAD_ACC: begin
                res_val = mem_rd;
                wr_acc = 1'b1;
            end
            core_pkg::OP_STORE_ACC: begin
                wr_mem = 1'b1;
            end
            core_pkg::OP_LOAD_IMM: begin
                res_val = ins.arg;
                wr_acc = 1'b1;
            end
            core_pkg::OP_ADDSUB: begin
                res_val = sum9[7:0];
                new_carry = sum9[8];
                upd_carry = 1'b1;
                upd_zero = 1'b1;
                wr_mem = ins.sub[`SUB_DEST_MEM] && !ins.sub[`SUB_IMM];
                wr_acc = !wr_mem;
            end
            core_pkg::OP_INCDEC: begin
                res_val = ins.sub[`SUB_SUBTRACT] ? mem_rd - `BYTE_ONE
                    : mem_rd + `BYTE_ONE;
                upd_zero = 1'b1;
                wr_mem = ins.sub[`SUB_DEST_MEM];
                wr_acc = !ins.sub[`SUB_DEST_MEM];
            end
            core_pkg::OP_LOGIC: begin
                case (ins.sub[1:0])
                    2'h0: res_val = acc_q & opb;
                    2'h1: res_val = acc_q | opb;
                    2'h2: res_val = acc_q ^ opb;
                    default: res_val = ~mem_rd;
                endcase
                upd_zero = 1'b1;
                wr_mem = ins.sub[`SUB_LOGIC_DEST] && !ins.sub[`SUB_IMM];
                wr_acc = !wr_mem;
            end
            core_pkg::OP_ROTATE: begin
                case (ins.sub[1:0])
                    2'h0: res_val = {mem_rd[0], mem_rd[7:1]};
                    2'h1: res_val = {mem_rd[6:0], mem_rd[7]};
                    2'h2: res_val = {flags_q.carry, mem_rd[7:1]};
                    default: res_val = {mem_rd[6:0], flags_q.carry};
                endcase
                new_carry = ins.sub[0] ? mem_rd[7] : mem_rd[0];
                upd_carry = ins.sub[1];
                wr_mem = ins.sub[`SUB_LOGIC_DEST];
                wr_acc = !ins.sub[`SUB_LOGIC_DEST];
            end
            core_pkg::OP_BIT_SET: begin
                res_val = mem_rd | bit_mask;
                wr_mem = 1'b1;
            end
            core_pkg::OP_BIT_CLEAR: begin
                res_val = mem_rd & ~bit_mask;
                wr_mem = 1'b1;
            end
            default: begin
                res_val = acc_q;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wake1_q <= 1'b0;
            wake2_q <= 1'b0;
            wake3_q <= 1'b0;
        end else begin
            wake1_q <= wake_pin;
            wake2_q <= wake1_q;
            wake3_q <= wake2_q;
        end
    end

    // Phase counter is the four-clock instruction cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase_q <= `PH_FIRST;
        end else if (st_q == core_pkg::ST_HALT) begin
            phase_q <= `PH_FIRST;
        end else begin
            phase_q <= phase_q + `PH_STEP;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= core_pkg::ST_RUN;
        end else if (exec && ins.op == core_pkg::OP_HALT) begin
            st_q <= core_pkg::ST_HALT;
        end else if (exec && branch) begin
            st_q <= core_pkg::ST_EXTRA;
        end else if (extra_end) begin
            st_q <= core_pkg::ST_RUN;
        end else if (halted && wake2_q && wake3_q) begin
            st_q <= core_pkg::ST_RUN;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pc_q <= `BYTE_ZERO;
            sp_q <= '0;
            tbl_q <= 1'b0;
        end else if (exec) begin
            tbl_q <= (ins.op == core_pkg::OP_TABLE_READ);
            if (ins.op == core_pkg::OP_JUMP) begin
                pc_q <= ins.arg;
            end else if (ins.op == core_pkg::OP_CALL) begin
                pc_q <= ins.arg;
                sp_q <= sp_q + SP_W'(`STACK_STEP);
            end else if (ins.op == core_pkg::OP_RETURN) begin
                pc_q <= stk_q[sp_dn];
                sp_q <= sp_dn;
            end else if (pcl_wr) begin
                pc_q <= res_val;
            end else if (skip_taken) begin
                pc_q <= pc_q + `SKIP_STEP;
            end else begin
                pc_q <= pc_q + `PC_STEP;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (exec && ins.op == core_pkg::OP_CALL) begin
            stk_q[sp_q] <= pc_q + `PC_STEP;
        end
        if (exec && wr_mem && !pcl_wr) begin
            mem_q[idx] <= res_val;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_q <= `BYTE_ZERO;
            flags_q <= '0;
        end else if (extra_end && tbl_q) begin
            acc_q <= pm_data[7:0];
        end else if (exec) begin
            if (wr_acc) begin
                acc_q <= res_val;
            end
            if (upd_carry) begin
                flags_q.carry <= new_carry;
            end
            if (upd_zero) begin
                flags_q.zero <= (res_val == `BYTE_ZERO);
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_second_cycle;
        (st_q == core_pkg::ST_EXTRA && !retire) [*3]
            ##1 (st_q == core_pkg::ST_EXTRA && retire);
    endsequence

    chk_retire_phase: assert property (
        retire |-> phase_q == `PH_LAST ##1 phase_q == `PH_FIRST)
        else $error("retire off the last phase");
    chk_single_cycle: assert property (
        exec && ordinary |=> st_q == core_pkg::ST_RUN
            && pc_q == $past(pc_q) + `PC_STEP)
        else $error("ordinary instruction not single cycle");
    chk_branch_two: assert property (
        exec && ins.op inside {core_pkg::OP_JUMP, core_pkg::OP_CALL,
            core_pkg::OP_RETURN, core_pkg::OP_TABLE_READ}
            |=> s_second_cycle)
        else $error("branch did not take two cycles");
    chk_pcl_jump: assert property (
        exec && pcl_wr |=> pc_q == $past(res_val) ##0 s_second_cycle)
        else $error("program counter low write not a jump");
    chk_skip_taken: assert property (
        skip_taken |=> pc_q == $past(pc_q) + `SKIP_STEP ##0 s_second_cycle)
        else $error("taken skip wrong");
    chk_skip_not: assert property (
        exec && is_skip && !skip_taken |=> st_q == core_pkg::ST_RUN
            && pc_q == $past(pc_q) + `PC_STEP)
        else $error("untaken skip wrong");
    chk_call_save: assert property (
        exec && ins.op == core_pkg::OP_CALL
            |=> stk_q[$past(sp_q)] == $past(pc_q) + `PC_STEP)
        else $error("call return address wrong");
    chk_add_carry: assert property (
        exec && ins.op == core_pkg::OP_ADDSUB && !ins.sub[`SUB_SUBTRACT]
            && !ins.sub[`SUB_CARRY] |=> flags_q.carry ==
            ($past({2'b00, acc_q} + {2'b00, opb}) > `BYTE_MAX))
        else $error("add carry wrong");
    chk_incdec_one: assert property (
        exec && ins.op == core_pkg::OP_INCDEC && !ins.sub[`SUB_DEST_MEM]
            && !ins.sub[`SUB_SUBTRACT] |=> acc_q == $past(mem_rd) + `BYTE_ONE)
        else $error("increment not by one");
    chk_logic_zero: assert property (
        exec && ins.op == core_pkg::OP_LOGIC
            |=> flags_q.zero == ($past(res_val) == `BYTE_ZERO))
        else $error("zero flag wrong after logic");
    chk_bit_only: assert property (
        exec && ins.op == core_pkg::OP_BIT_SET && ins.arg != `PCL_ADDR
            |=> mem_q[$past(idx)] == ($past(mem_rd) | $past(bit_mask)))
        else $error("bit set touched other bits");
    chk_halt_enter: assert property (
        exec && ins.op == core_pkg::OP_HALT |=> halted && !retire)
        else $error("halt not entered");
endmodule : mcu_instruction_execution

// ---- test/prog_mem.sv ----
`timescale 1ns/100ps
module prog_mem (
    // Fetch port
    input wire logic [7:0] addr,
    output core_pkg::instr_s data
);
    core_pkg::instr_s words [0:255];

    // Same-cycle read; table bytes live here as well
    assign data = words[addr];

    task load(input logic [7:0] a, input core_pkg::instr_s w);
        words[a] = w;
    endtask : load
endmodule : prog_mem

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [7:0] acc;
        logic ec;
        logic ez;
        logic [7:0] pc;
        logic [3:0] cyc;
    } note_s;
    logic clock;
    logic nrst;
    logic wake_pin;
    logic [7:0] pm_addr;
    core_pkg::instr_s pm_data;
    logic halted;
    logic retire;
    logic [7:0] acc;
    core_pkg::flags_s flags;
    note_s notes[$];
    int n_mismatch = 0;
    int checked = 0;
    int n_clk = 0;
    logic [7:0] ea, pc, dm1, dm2;
    logic ec, ez;

    prog_mem i_pm (.addr(pm_addr), .data(pm_data));
    mcu_instruction_execution i_dut (
        .clock(clock), .nrst(nrst), .pm_addr(pm_addr), .pm_data(pm_data),
        .wake_pin(wake_pin), .halted(halted), .retire(retire), .acc(acc),
        .flags(flags)
    );

    task check(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task print_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // Word at pc, with the state expected once it retires
    task put(input logic [3:0] op, input logic [3:0] sub,
             input logic [7:0] arg, input logic [7:0] nxt,
             input logic [3:0] cyc);
        i_pm.load(pc, {op, sub, arg});
        notes.push_back('{ea, ec, ez, nxt, cyc});
        pc = nxt;
    endtask : put

    task one(input logic [3:0] op, input logic [3:0] sub,
             input logic [7:0] arg);
        put(op, sub, arg, pc + 8'h01, 4'h4);
    endtask : one

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Clock count after release; nrst settles well before each rising edge
    always @(posedge clock) begin
        if (nrst === 1'b1) n_clk++;
    end

    // Retire is seen mid-cycle, away from the edge that launches it
    initial begin
        int last;
        logic pend;
        note_s nt;
        last = 0;
        pend = 1'b0;
        forever begin
            @(negedge clock);
            if (pend) begin
                if (notes.size() == 0) begin
                    check(18'h3FFFF, 18'h0);
                end else begin
                    nt = notes.pop_front();
                    check({acc, flags, pm_addr}, nt[21:4]);
                    if (nt.cyc != 4'h0) begin
                        check(18'(n_clk - last), {14'h0, nt.cyc});
                    end
                end
                last = n_clk;
            end
            pend = (retire === 1'b1);
        end
    end

    initial begin
        #(5 * 4000);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        logic [8:0] s;
        logic [7:0] a, b, c, t;
        int k, j, n;
        nrst = 1'b0;
        wake_pin = 1'b0;
        void'($urandom(9));
        a = $urandom;
        b = $urandom;
        c = $urandom;
        // Stray fetches load a marker value and show up at once
        for (n = 0; n < 256; n++) i_pm.load(n[7:0], 16'h20EE);
        pc = 8'h00;
        ec = 1'b0;
        ez = 1'b0;
        ea = a;
        one(4'h2, 4'h0, a);
        dm1 = a;
        one(4'h1, 4'h0, 8'h01);
        ea = b;
        one(4'h2, 4'h0, b);
        s = {1'b0, b} + {1'b0, a};
        {ec, ea} = s;
        ez = (ea == 8'h00);
        one(4'h3, 4'h0, 8'h01);
        ea = 8'hFF;
        one(4'h2, 4'h0, 8'hFF);
        {ea, ec, ez} = 10'h003;
        one(4'h3, 4'h8, 8'h01);
        {ea, ec, ez} = 10'h004;
        one(4'h3, 4'hA, 8'h00);
        {ea, ec, ez} = 10'h3FE;
        one(4'h3, 4'hC, 8'h02);
        s = {1'b0, ea} - {1'b0, dm1} - {8'h00, ec};
        {ec, ea} = s;
        ez = (ea == 8'h00);
        one(4'h3, 4'h6, 8'h01);
        s = {1'b0, ea} + {1'b0, dm1};
        {ec, dm1} = s;
        ez = (dm1 == 8'h00);
        one(4'h3, 4'h1, 8'h01);
        ea = dm1 + 8'h01;
        ez = (ea == 8'h00);
        one(4'h4, 4'h0, 8'h01);
        dm1 = dm1 - 8'h01;
        ez = (dm1 == 8'h00);
        one(4'h4, 4'h5, 8'h01);
        ea = dm1;
        one(4'h0, 4'h0, 8'h01);
        for (k = 0; k < 4; k++) begin
            t = (k == 3) ? 8'h00 : 8'($urandom);
            ea = (k == 1) ? (ea | t) : (k == 2) ? (ea ^ t) : (ea & t);
            ez = (ea == 8'h00);
            one(4'h5, 4'h8 | 4'(k % 3), t);
        end
        ea = ~dm1;
        ez = (ea == 8'h00);
        one(4'h5, 4'h3, 8'h01);
        for (k = 0; k < 4; k++) begin
            t = dm1;
            case (k)
                0: dm1 = {t[0], t[7:1]};
                1: dm1 = {t[6:0], t[7]};
                2: {dm1, ec} = {ec, t};
                default: {ec, dm1} = {t, ec};
            endcase
            one(4'h6, 4'h4 | 4'(k), 8'h01);
            ea = dm1;
            one(4'h0, 4'h0, 8'h01);
        end
        k = $urandom % 8;
        j = (k + 3) % 8;
        dm2 = ea;
        one(4'h1, 4'h0, 8'h02);
        dm2[k] = 1'b1;
        one(4'h9, 4'(k), 8'h02);
        dm2[j] = 1'b0;
        one(4'hA, 4'(j), 8'h02);
        ea = dm2;
        one(4'h0, 4'h0, 8'h02);
        put(4'h8, 4'h8 | 4'(k), 8'h02, pc + 8'h02, 4'h8);
        one(4'h8, 4'h8 | 4'(j), 8'h02);
        put(4'h7, 4'h1, 8'h02, pc + 8'h02, 4'h8);
        one(4'h7, 4'h0, 8'h02);
        put(4'hB, 4'h0, 8'h80, 8'h80, 4'h8);
        put(4'hC, 4'h0, 8'hA0, 8'hA0, 4'h8);
        put(4'hD, 4'h0, 8'h00, 8'h81, 4'h8);
        put(4'hC, 4'h0, 8'hA8, 8'hA8, 4'h8);
        put(4'hD, 4'h1, 8'h00, 8'h82, 4'h8);
        ea = 8'hC0;
        one(4'h2, 4'h0, 8'hC0);
        put(4'h1, 4'h0, 8'h00, 8'hC0, 4'h8);
        ea = 8'hF0;
        one(4'h2, 4'h0, 8'hF0);
        i_pm.load(8'hF0, {8'h00, c});
        ea = c;
        put(4'hE, 4'h0, 8'h00, pc + 8'h01, 4'h8);
        i_pm.load(pc, 16'hF000);
        pc = pc + 8'h01;
        ea = 8'h5A;
        put(4'h2, 4'h0, 8'h5A, pc + 8'h01, 4'h0);
        i_pm.load(pc, 16'hF000);
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        for (n = 0; n < 3000 && halted !== 1'b1; n++) @(negedge clock);
        repeat (20) @(negedge clock);
        check({17'h0, halted}, 18'h1);
        check(18'(notes.size()), 18'h1);
        wake_pin = 1'b1;
        for (n = 0; n < 50 && halted !== 1'b0; n++) @(negedge clock);
        wake_pin = 1'b0;
        repeat (30) @(negedge clock);
        check(18'(notes.size()), 18'h0);
        check({17'h0, halted}, 18'h1);
        print_verdict();
    end
endmodule : testbench
